// ==== hdl/tmrev_pkg.sv ====
/*
 * constants for the 16-bit timer/event counter: register offsets,
 * field positions, reset values and timing counts.
 * assumes a plain single-cycle register port and a 100 MHz clock.
 */
package tmrev_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    // register offsets (register port word addresses)
    localparam logic [3:0]  OFF_COUNT       = 4'h0;
    localparam logic [3:0]  OFF_CC_FIRST    = 4'h1;
    localparam logic [3:0]  OFF_CC_SECOND   = 4'h2;
    localparam logic [3:0]  OFF_MODE_CTRL   = 4'h3;
    localparam logic [3:0]  OFF_PRESCALER   = 4'h4;
    localparam logic [3:0]  OFF_CAP_CTRL    = 4'h5;
    localparam logic [3:0]  OFF_OSP_CTRL    = 4'h6;
    localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h7;
    localparam logic [3:0]  OFF_IRQ_MASK    = 4'h8;
    // timer_mode_control fields
    localparam int          MODE_LO_BIT     = 2;
    localparam int          MODE_HI_BIT     = 3;
    localparam logic [1:0]  MODE_STOP       = 2'h0;
    localparam logic [1:0]  MODE_CLR_EDGE   = 2'h1;
    localparam logic [1:0]  MODE_FREE       = 2'h2;
    localparam logic [1:0]  MODE_CLR_MATCH  = 2'h3;
    localparam int          OVF_BIT         = 0;
    // prescaler_mode_reg fields
    localparam int          CLKSEL_LO_BIT   = 0;
    localparam int          CLKSEL_HI_BIT   = 1;
    localparam int          EDGE_LO_BIT     = 4;
    localparam int          EDGE_HI_BIT     = 5;
    localparam int          EDGE2_LO_BIT    = 6;
    localparam int          EDGE2_HI_BIT    = 7;
    localparam logic [1:0]  CLKSEL_EVENT    = 2'h3;
    localparam logic [1:0]  EDGE_FALL       = 2'h0;
    localparam logic [1:0]  EDGE_RISE       = 2'h1;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;
    // capture control: bit0 first reg captures, bit1 second reg captures,
    // bit2 first reg captures on the second pin instead of the trigger pin
    localparam int          CAP_FIRST_BIT   = 0;
    localparam int          CAP_SECOND_BIT  = 1;
    localparam int          CAP_SRC_BIT     = 2;
    // one-shot control: bit0 enable, bit1 soft trigger (self clearing),
    // bit2 pulse output level, read only
    localparam int          OSP_EN_BIT      = 0;
    localparam int          OSP_TRIG_BIT    = 1;
    localparam int          OSP_OUT_BIT     = 2;
    // interrupt status bits
    localparam int          IRQ_MATCH0      = 0;
    localparam int          IRQ_MATCH1      = 1;
    localparam int          IRQ_OVF         = 2;
    localparam int          IRQ_W           = 3;
    localparam logic [15:0] RESET_VALUE     = 16'h0000;
    localparam logic [15:0] COUNT_MAX       = 16'hffff;
    // prescaler divide ratios, in device clocks
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          DIV_A           = 4;
    localparam int          DIV_B           = 16;
    localparam int          DIV_C           = 64;
endpackage

// ==== hdl/tmrev_edge_det.sv ====
/*
 * two-stage synchroniser and selectable valid-edge detector for one pin.
 * assumes the pin is asynchronous to clk_i.
 */
`timescale 1ns/1ps
module tmrev_edge_det (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       pin_i,
    input  wire logic [1:0] edge_sel_i,
    output logic            level_o,
    output logic            edge_o
);
    logic sync_a;
    logic sync_b;
    logic prev;
    wire  rise = sync_b & ~prev;
    wire  fall = ~sync_b & prev;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev   <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            prev   <= sync_b;
        end
    end

    assign level_o = sync_b;
    assign edge_o  = (edge_sel_i == tmrev_pkg::EDGE_FALL) ? fall :
                     (edge_sel_i == tmrev_pkg::EDGE_RISE) ? rise :
                     (edge_sel_i == tmrev_pkg::EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule // tmrev_edge_det

// ==== hdl/tmrev_timer.sv ====
/*
 * 16-bit timer/event counter with two capture/compare registers,
 * one-shot pulse output and a masked interrupt.
 * assumes software keeps the documented programming order and that the
 * two pins are asynchronous inputs.
 */
// Summary of operation
// - nonzero mode field starts counting; zero stops
// - first match may slip one count clock
// - pin edge restarts one-shot, except in event count mode
// - compare contents hold last value after stop
// - trigger edge select in prescaler bits 4,5
// - event count read from counter register
// - overflow flag also set on wrap at all ones
// - capture beats a simultaneous register write
`timescale 1ns/1ps
module tmrev_timer #(
    parameter int DIV_A = tmrev_pkg::DIV_A,
    parameter int DIV_B = tmrev_pkg::DIV_B,
    parameter int DIV_C = tmrev_pkg::DIV_C
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        trigger_capture_pin_i,
    input  wire logic        second_capture_pin_i,
    output logic             pulse_o,
    output logic             irq_o
);
    // ********************************
    // registers
    // ********************************
    logic [15:0] timer_count_register;
    logic [15:0] capture_compare_first;
    logic [15:0] capture_compare_second;
    logic [7:0]  timer_mode_control;
    logic [7:0]  prescaler_mode_reg;
    logic [2:0]  cap_ctrl;
    logic        osp_en;
    logic        osp_active;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [7:0]  presc;

    // ********************************
    // decode
    // ********************************
    wire wr_mode  = wr_i && addr_i == tmrev_pkg::OFF_MODE_CTRL;
    wire wr_cc0   = wr_i && addr_i == tmrev_pkg::OFF_CC_FIRST;
    wire wr_cc1   = wr_i && addr_i == tmrev_pkg::OFF_CC_SECOND;
    wire wr_cnt   = wr_i && addr_i == tmrev_pkg::OFF_COUNT;
    wire wr_osp   = wr_i && addr_i == tmrev_pkg::OFF_OSP_CTRL;
    wire wr_stat  = wr_i && addr_i == tmrev_pkg::OFF_IRQ_STATUS;

    wire [1:0] op_mode = {timer_mode_control[tmrev_pkg::MODE_HI_BIT],
                          timer_mode_control[tmrev_pkg::MODE_LO_BIT]};
    wire running = op_mode != tmrev_pkg::MODE_STOP;
    wire [1:0] clk_sel = {prescaler_mode_reg[tmrev_pkg::CLKSEL_HI_BIT],
                          prescaler_mode_reg[tmrev_pkg::CLKSEL_LO_BIT]};
    wire [1:0] trig_edge_sel = {prescaler_mode_reg[tmrev_pkg::EDGE_HI_BIT],
                                prescaler_mode_reg[tmrev_pkg::EDGE_LO_BIT]};
    wire [1:0] cap2_edge_sel = {prescaler_mode_reg[tmrev_pkg::EDGE2_HI_BIT],
                                prescaler_mode_reg[tmrev_pkg::EDGE2_LO_BIT]};

    // ********************************
    // pins
    // ********************************
    logic trig_edge;
    logic cap2_edge;

    tmrev_edge_det u_trig (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      (trigger_capture_pin_i),
        .edge_sel_i (trig_edge_sel),
        .level_o    (),
        .edge_o     (trig_edge)
    );

    tmrev_edge_det u_cap2 (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .pin_i      (second_capture_pin_i),
        .edge_sel_i (cap2_edge_sel),
        .level_o    (),
        .edge_o     (cap2_edge)
    );

    // pins are ignored while stopped
    wire trig_ev = running & trig_edge;
    wire cap2_ev = running & cap2_edge;

    // ********************************
    // count clock
    // ********************************
    // prescaler free-runs from reset, so the first tick after start lands
    // anywhere within one count-clock period
    wire tick_a = presc[1:0] == 2'(DIV_A - 1);
    wire tick_b = presc[3:0] == 4'(DIV_B - 1);
    wire tick_c = presc[5:0] == 6'(DIV_C - 1);
    wire tick = !running ? 1'b0 :
                (clk_sel == 2'h0) ? tick_a :
                (clk_sel == 2'h1) ? tick_b :
                (clk_sel == 2'h2) ? tick_c : trig_ev;

    // ********************************
    // compare, capture, clear
    // ********************************
    wire match0 = tick && timer_count_register == capture_compare_first;
    wire match1 = tick && timer_count_register == capture_compare_second;
    wire wrap   = tick && timer_count_register == tmrev_pkg::COUNT_MAX;
    wire soft_trig = wr_osp & wdata_i[tmrev_pkg::OSP_TRIG_BIT] & running;
    // pin edge restarts the one-shot with any count clock except the trigger pin itself
    wire osp_start = osp_en & (soft_trig | (trig_ev & clk_sel != tmrev_pkg::CLKSEL_EVENT));
    wire clr_edge = op_mode == tmrev_pkg::MODE_CLR_EDGE && trig_ev
                    && clk_sel != tmrev_pkg::CLKSEL_EVENT;
    wire clr_match = op_mode == tmrev_pkg::MODE_CLR_MATCH && match0;
    wire clr_cnt = clr_edge | clr_match | osp_start;
    // overflow also when the first compare is all ones and the count wraps
    wire ovf_ev = wrap | (clr_match &&
                  capture_compare_first == tmrev_pkg::COUNT_MAX);
    wire cap0_src = cap_ctrl[tmrev_pkg::CAP_SRC_BIT] ? cap2_ev : trig_ev;
    wire cap0_ev = cap_ctrl[tmrev_pkg::CAP_FIRST_BIT] & cap0_src;
    wire cap1_ev = cap_ctrl[tmrev_pkg::CAP_SECOND_BIT] & trig_ev;
    wire [15:0] next_count = clr_cnt ? tmrev_pkg::RESET_VALUE :
                             tick ? 16'(timer_count_register + 16'h0001) :
                             timer_count_register;
    wire [2:0] irq_set = {ovf_ev, match1 | cap1_ev, match0 | cap0_ev};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            presc <= 8'h00;
        end else begin
            presc <= 8'(presc + 8'h01);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !running) begin
            timer_count_register <= tmrev_pkg::RESET_VALUE;
        end else if (wr_cnt) begin
            timer_count_register <= wdata_i;
        end else begin
            timer_count_register <= next_count;
        end
    end

    // capture beats a same-cycle software write; contents after a stop
    // are simply whatever was last stored
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            capture_compare_first  <= tmrev_pkg::RESET_VALUE;
            capture_compare_second <= tmrev_pkg::RESET_VALUE;
        end else begin
            if (cap0_ev) begin
                capture_compare_first <= timer_count_register;
            end else if (wr_cc0) begin
                capture_compare_first <= wdata_i;
            end
            if (cap1_ev) begin
                capture_compare_second <= timer_count_register;
            end else if (wr_cc1) begin
                capture_compare_second <= wdata_i;
            end
        end
    end

    // ********************************
    // control registers
    // ********************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_mode_control <= 8'h00;
            prescaler_mode_reg <= 8'h00;
            cap_ctrl           <= 3'h0;
            osp_en             <= 1'b0;
            irq_mask           <= 3'h0;
        end else begin
            if (wr_mode) begin
                timer_mode_control <= wdata_i[7:0];
            end
            // clock select and edge bits are only honoured while stopped
            if (wr_i && addr_i == tmrev_pkg::OFF_PRESCALER && !running) begin
                prescaler_mode_reg <= wdata_i[7:0];
            end
            if (wr_i && addr_i == tmrev_pkg::OFF_CAP_CTRL) begin
                cap_ctrl <= wdata_i[2:0];
            end
            if (wr_osp) begin
                osp_en <= wdata_i[tmrev_pkg::OSP_EN_BIT];
            end
            if (wr_i && addr_i == tmrev_pkg::OFF_IRQ_MASK) begin
                irq_mask <= wdata_i[2:0];
            end
        end
    end

    // ********************************
    // one-shot pulse and interrupts
    // ********************************
    // pulse rises on second-compare match, falls on first-compare match;
    // a restart mid-pulse is not guarded, software and pin must wait
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !running || !osp_en) begin
            osp_active <= 1'b0;
            pulse_o    <= 1'b0;
        end else begin
            if (osp_start) begin
                osp_active <= 1'b1;
            end else if (match0 && osp_active) begin
                osp_active <= 1'b0;
            end
            if (osp_start || match0) begin
                pulse_o <= 1'b0;
            end else if (match1 && osp_active) begin
                pulse_o <= 1'b1;
            end
        end
    end

    // set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~(wr_stat ? wdata_i[2:0] : 3'h0)) | irq_set;
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // ********************************
    // read port
    // ********************************
    wire [15:0] rd_mux =
        (addr_i == tmrev_pkg::OFF_COUNT)      ? timer_count_register :
        (addr_i == tmrev_pkg::OFF_CC_FIRST)   ? capture_compare_first :
        (addr_i == tmrev_pkg::OFF_CC_SECOND)  ? capture_compare_second :
        (addr_i == tmrev_pkg::OFF_MODE_CTRL)  ? {8'h00, timer_mode_control[7:1],
                                                 irq_status[tmrev_pkg::IRQ_OVF]} :
        (addr_i == tmrev_pkg::OFF_PRESCALER)  ? {8'h00, prescaler_mode_reg} :
        (addr_i == tmrev_pkg::OFF_CAP_CTRL)   ? {13'h0000, cap_ctrl} :
        (addr_i == tmrev_pkg::OFF_OSP_CTRL)   ? {13'h0000, pulse_o, 1'b0, osp_en} :
        (addr_i == tmrev_pkg::OFF_IRQ_STATUS) ? {13'h0000, irq_status} :
        (addr_i == tmrev_pkg::OFF_IRQ_MASK)   ? {13'h0000, irq_mask} : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 16'h0000;
        end
    end
endmodule // tmrev_timer

// ==== verification/tmrev_props.sv ====
/* checker for the timer's register port, pulse and interrupt outputs.
   sees only the timer's ports; attached by the bind at the foot. */
`timescale 1ns/1ps
module tmrev_props (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic        trigger_capture_pin_i,
    input wire logic        second_capture_pin_i,
    input wire logic        pulse_o,
    input wire logic        irq_o
);
    logic [1:0] mode;
    logic [1:0] edge_sel;
    logic       osp_en;
    logic [2:0] mask;
    wire        wr_mode = wr_i && addr_i == tmrev_pkg::OFF_MODE_CTRL;
    // prescaler writes are refused while running, so the shadow follows suit
    wire        wr_pre  = wr_i && addr_i == tmrev_pkg::OFF_PRESCALER && mode == 2'h0;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode     <= 2'h0;
            edge_sel <= 2'h0;
            osp_en   <= 1'b0;
            mask     <= 3'h0;
        end else begin
            if (wr_mode) mode <= wdata_i[3:2];
            if (wr_pre) edge_sel <= wdata_i[5:4];
            if (wr_i && addr_i == tmrev_pkg::OFF_OSP_CTRL) osp_en <= wdata_i[0];
            if (wr_i && addr_i == tmrev_pkg::OFF_IRQ_MASK) mask <= wdata_i[2:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_rdata_quiet: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd_i && addr_i > 4'h8 |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_mode_readback: assert property (rd_i && addr_i == tmrev_pkg::OFF_MODE_CTRL
        |=> rdata_o[3:2] == mode) else $error("mode field readback wrong");
    a_edge_readback: assert property (rd_i && addr_i == tmrev_pkg::OFF_PRESCALER
        |=> rdata_o[5:4] == edge_sel) else $error("edge select readback wrong");
    a_count_stopped: assert property (rd_i && addr_i == tmrev_pkg::OFF_COUNT && mode == 2'h0
        && $past(mode) == 2'h0 |=> rdata_o == 16'h0000) else $error("count moved while stopped");
    a_stop_no_pulse: assert property (mode == 2'h0 && $past(mode) == 2'h0 |-> !pulse_o)
        else $error("pulse while stopped");
    a_osp_off_quiet: assert property (!osp_en && !$past(osp_en) |-> !pulse_o)
        else $error("pulse with one-shot disabled");
    a_mask_quiet: assert property (mask == 3'h0 |-> !irq_o)
        else $error("interrupt with all sources masked");
endmodule // tmrev_props
bind tmrev_timer tmrev_props tmrev_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .trigger_capture_pin_i(trigger_capture_pin_i),
    .second_capture_pin_i(second_capture_pin_i), .pulse_o(pulse_o), .irq_o(irq_o));

// ==== verification/tmrev_pin_model.sv ====
/* model of the two external pins: bit 0 trigger/capture pin, bit 1 second pin.
   a request gives one high pulse of HOLD cycles, then HOLD low. */
`timescale 1ns/1ps
module tmrev_pin_model #(
    parameter int HOLD = 4
) (
    input  wire logic       clk_i,
    input  wire logic [1:0] req_i,
    output logic      [1:0] pin_o
);
    int cnt [2];
    initial begin
        cnt[0] = 0;
        cnt[1] = 0;
        pin_o = 2'h0;
    end
    // both pins driven as real inputs, levels held well past the sync depth
    always @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            // a request while a pulse is still out is dropped, never retriggers
            if (req_i[i] && cnt[i] == 0) cnt[i] <= 2 * HOLD;
            else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
            pin_o[i] <= cnt[i] > HOLD;
        end
    end
endmodule // tmrev_pin_model

// ==== verification/test_tmrev_timer.sv ====
/* self-checking bench for the timer: register tasks and scenario sequence.
   assumes the pin model beside it and a 100 MHz clock. */
`timescale 1ns/1ps
module test_tmrev_timer;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic        pulse_o;
    logic        irq_o;
    logic [1:0]  req = 2'h0;
    logic [1:0]  pins;
    logic [15:0] d;
    int          fail_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    tmrev_timer tmrev_timer_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .trigger_capture_pin_i(pins[0]), .second_capture_pin_i(pins[1]),
        .pulse_o(pulse_o), .irq_o(irq_o));
    tmrev_pin_model tmrev_pin_model_inst (.clk_i(clk_i), .req_i(req), .pin_o(pins));
    initial forever #5 clk_i = ~clk_i;
    /**********************************************************************
     * tasks
     **********************************************************************/
    task automatic final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // a spare edge after each strobe keeps back-to-back calls race free
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask
    task automatic fire(input int i);
        req[i] <= 1'b1;
        @(posedge clk_i);
        req[i] <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic wait_pulse(input logic lvl);
        int n;
        n = 0;
        while (pulse_o !== lvl && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk({15'h0000, pulse_o}, {15'h0000, lvl});
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    /**********************************************************************
     * scenarios
     **********************************************************************/
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(tmrev_pkg::OFF_COUNT, d); chk(d, 16'h0000);
        rd(4'hc, d); chk(d, 16'h0000);
        wr(tmrev_pkg::OFF_PRESCALER, 16'h0013);
        rd(tmrev_pkg::OFF_PRESCALER, d); chk(d[5:0], 6'h13);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0008);
        wr(tmrev_pkg::OFF_PRESCALER, 16'h0000);
        rd(tmrev_pkg::OFF_PRESCALER, d); chk(d[5:0], 6'h13);
        for (int k = 0; k < 3; k++) fire(0);
        fire(1);
        rd(tmrev_pkg::OFF_COUNT, d); chk(d, 16'h0003);
        wr(tmrev_pkg::OFF_COUNT, 16'hfffe);
        fire(0);
        chk({15'h0000, irq_o}, 16'h0000);
        fire(0);
        rd(tmrev_pkg::OFF_COUNT, d); chk(d, 16'h0000);
        rd(tmrev_pkg::OFF_IRQ_STATUS, d); chk(d & 16'h0004, 16'h0004);
        wr(tmrev_pkg::OFF_IRQ_MASK, 16'h0004);
        chk({15'h0000, irq_o}, 16'h0001);
        wr(tmrev_pkg::OFF_IRQ_STATUS, 16'h0004);
        chk({15'h0000, irq_o}, 16'h0000);
        wr(tmrev_pkg::OFF_IRQ_MASK, 16'h0000);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0000);
        rd(tmrev_pkg::OFF_COUNT, d); chk(d, 16'h0000);
        // one-shot: compare values kept nonzero, retrigger only after the pulse ends
        wr(tmrev_pkg::OFF_PRESCALER, 16'h0010);
        wr(tmrev_pkg::OFF_CC_FIRST, 16'h0008);
        wr(tmrev_pkg::OFF_CC_SECOND, 16'h0002);
        wr(tmrev_pkg::OFF_OSP_CTRL, 16'h0001);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0008);
        wr(tmrev_pkg::OFF_OSP_CTRL, 16'h0003);
        wait_pulse(1'b1);
        wait_pulse(1'b0);
        fire(0);
        wait_pulse(1'b1);
        wait_pulse(1'b0);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0000);
        // capture: second reg on trigger pin events, first reg on the second pin
        wr(tmrev_pkg::OFF_OSP_CTRL, 16'h0000);
        wr(tmrev_pkg::OFF_PRESCALER, 16'h0013);
        wr(tmrev_pkg::OFF_CAP_CTRL, 16'h0007);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0008);
        fire(0);
        fire(0);
        fire(1);
        rd(tmrev_pkg::OFF_CC_SECOND, d); chk(d, 16'h0001);
        rd(tmrev_pkg::OFF_CC_FIRST, d); chk(d, 16'h0002);
        // clear on first-compare match, counting trigger pin events
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0000);
        wr(tmrev_pkg::OFF_CAP_CTRL, 16'h0000);
        wr(tmrev_pkg::OFF_CC_FIRST, 16'h0002);
        wr(tmrev_pkg::OFF_IRQ_STATUS, 16'h0007);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h000c);
        for (int k = 0; k < 4; k++) fire(0);
        rd(tmrev_pkg::OFF_COUNT, d); chk(d, 16'h0001);
        rd(tmrev_pkg::OFF_IRQ_STATUS, d); chk(d & 16'h0001, 16'h0001);
        // clear on trigger edge, slowest count clock so at most one tick follows
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0000);
        wr(tmrev_pkg::OFF_PRESCALER, 16'h0012);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0004);
        wr(tmrev_pkg::OFF_COUNT, 16'h1234);
        fire(0);
        rd(tmrev_pkg::OFF_COUNT, d); chk({15'h0000, d < 16'h0002}, 16'h0001);
        wr(tmrev_pkg::OFF_MODE_CTRL, 16'h0000);
        final_report();
    end
endmodule // test_tmrev_timer
